// ===== hdl/csr_alu.v
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.vh"
module csr_alu (
  input wire [3:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire [7:0] flags_in,
  output reg [7:0] result,
  output reg [7:0] flags_out
);
  reg [8:0] sum;
  reg cin;
  reg h;
  reg v;
  reg c;
  reg n;
  reg z_keep;
  always @* begin
    cin = flags_in[`CSR_FLAG_C];
    sum = 9'h000;
    h = flags_in[`CSR_FLAG_H];
    v = 1'b0;
    c = flags_in[`CSR_FLAG_C];
    z_keep = 1'b0;
    result = a;
    // ==========================================
    // Operations
    // RULE2 three operation classes
    case (op)
      `CSR_OP_ADD, `CSR_OP_ADC: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == `CSR_OP_ADC) & cin};
        result = sum[7:0];
        // RULE9 half carry
        h = (a[3] & b[3]) | (b[3] & ~result[3]) | (~result[3] & a[3]);
        v = (a[7] & b[7] & ~result[7]) | (~a[7] & ~b[7] & result[7]);
        c = sum[8];
      end
      `CSR_OP_SUB, `CSR_OP_SBC, `CSR_OP_NEG: begin
        if (op == `CSR_OP_NEG) begin
          sum = 9'h000 - {1'b0, a};
          result = sum[7:0];
          h = result[3] | a[3];
          v = (result == 8'h80);
          c = (result != 8'h00);
        end else begin
          sum = {1'b0, a} - {1'b0, b} - {8'h00, (op == `CSR_OP_SBC) & cin};
          result = sum[7:0];
          h = (~a[3] & b[3]) | (b[3] & result[3]) | (result[3] & ~a[3]);
          v = (a[7] & ~b[7] & ~result[7]) | (~a[7] & b[7] & result[7]);
          c = sum[8];
          // Carry-chained subtract keeps Z only if already set, for multi-byte compares.
          z_keep = (op == `CSR_OP_SBC);
        end
      end
      `CSR_OP_AND: result = a & b;
      `CSR_OP_OR: result = a | b;
      `CSR_OP_XOR: result = a ^ b;
      `CSR_OP_COM: begin
        result = ~a;
        c = 1'b1;
      end
      `CSR_OP_INC: begin
        result = a + 8'h01;
        v = (a == 8'h7F);
      end
      `CSR_OP_DEC: begin
        result = a - 8'h01;
        v = (a == 8'h80);
      end
      `CSR_OP_LSR, `CSR_OP_ROR, `CSR_OP_ASR: begin
        if (op == `CSR_OP_LSR) begin
          result = {1'b0, a[7:1]};
        end else if (op == `CSR_OP_ROR) begin
          result = {cin, a[7:1]};
        end else begin
          result = {a[7], a[7:1]};
        end
        c = a[0];
        v = result[7] ^ a[0];
      end
      `CSR_OP_SWAP: result = {a[3:0], a[7:4]};
      default: result = b;
    endcase
    n = result[7];
    flags_out = flags_in;
    if (op != `CSR_OP_SWAP && op != `CSR_OP_MOV) begin
      flags_out[`CSR_FLAG_H] = h;
      // RULE11 overflow flag
      flags_out[`CSR_FLAG_V] = v;
      // RULE12 negative flag
      flags_out[`CSR_FLAG_N] = n;
      // RULE10 sign is N xor V
      flags_out[`CSR_FLAG_S] = n ^ v;
      // RULE13 zero flag
      flags_out[`CSR_FLAG_Z] = (result == 8'h00) & (~z_keep | flags_in[`CSR_FLAG_Z]);
      // RULE14 carry flag
      flags_out[`CSR_FLAG_C] = c;
    end
  end
endmodule // csr_alu
`default_nettype wire

// ===== hdl/csr_core.v
// Notes on behaviour
// RULE1 - ALU reaches all 32 registers, one cycle
// RULE2 - Arithmetic, logical and single-bit operations
// RULE3 - Every ALU operation updates the flags; here swap and move leave them unchanged
// RULE4 - Interrupt entry/return touch only enable bit
// RULE5 - Bit 7 low blocks every interrupt
// RULE6 - Interrupt taken clears enable, return sets it
// RULE7 - Set and clear enable instructions
// RULE8 - Bit 6 copy flag: store and load bit
// RULE9 - Bit 5 holds low nibble carry
// RULE10 - Bit 4 equals negative xor overflow
// RULE11 - Bit 3 holds signed overflow
// RULE12 - Bit 2 set on negative result
// RULE13 - Bit 1 set on zero result
// RULE14 - Bit 0 holds carry
// RULE15 - Four register file port schemes
// RULE16 - Registers appear at data addresses 0 to 31
// RULE17 - Top six registers form three pointers
// RULE18 - Stack grows downward; push lowers pointer
// RULE19 - Push minus one, call/interrupt minus two
// RULE20 - Pop plus one, returns plus two
// RULE21 - Pointer in two 8-bit I/O registers
// RULE22 - Software sets pointer above 0x60 first
// RULE23 - Interrupt return takes four cycles
// RULE24 - Reset loads documented initial values
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.vh"
module csr_core #(
  parameter SP_BITS = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire [4:0] rd_addr,
  input wire [4:0] rr_addr,
  input wire [7:0] imm,
  input wire use_imm,
  input wire alu_en,
  input wire [3:0] alu_op,
  input wire wr8_en,
  input wire [4:0] wr8_addr,
  input wire [7:0] wr8_data,
  input wire wr16_en,
  input wire [4:0] wr16_addr,
  input wire [15:0] wr16_data,
  input wire [4:0] rd16_addr,
  input wire bit_store,
  input wire bit_load,
  input wire [2:0] bit_sel,
  input wire set_global_irq,
  input wire clear_global_irq,
  input wire irq_take,
  input wire return_from_irq,
  input wire return_from_call,
  input wire call_push,
  input wire byte_push,
  input wire byte_pop,
  input wire [1:0] ptr_sel,
  input wire [1:0] ptr_mode,
  input wire [5:0] ptr_disp,
  input wire ptr_en,
  input wire [15:0] ds_addr,
  input wire ds_wr,
  input wire [7:0] ds_wdata,
  input wire io_wr,
  input wire [5:0] io_addr,
  input wire [7:0] io_wdata,
  output reg [7:0] rd_data,
  output reg [7:0] rr_data,
  output reg [15:0] rd16_data,
  output reg [7:0] alu_result,
  output reg [7:0] status_flags,
  output reg [7:0] stack_pointer_high,
  output reg [7:0] stack_pointer_low,
  output reg irq_enabled,
  output reg [15:0] ptr_addr,
  output reg ds_is_reg,
  output reg [7:0] ds_rdata,
  output reg [7:0] io_rdata,
  output reg return_from_irq_busy
);
  // ==========================================
  // Register file
  reg [7:0] regs [0:31];
  wire [7:0] op_b;
  wire [7:0] alu_res;
  wire [7:0] alu_flags;
  wire [15:0] sp_now;
  wire [15:0] sp_next;
  reg [2:0] sp_op;
  reg [2:0] return_from_irq_cnt;
  reg [7:0] next_flags;
  reg [15:0] ptr_base;
  reg [15:0] ptr_eff;
  reg [15:0] ptr_upd;
  reg ptr_write;
  reg [7:0] next_io_rdata;
  reg [7:0] next_sp_low;
  reg [7:0] next_sp_high;
  reg [2:0] next_return_from_irq_cnt;
  reg next_return_from_irq_busy;
  integer i;

  function [4:0] ptr_low_index;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: ptr_low_index = 5'h1A;
        2'h1: ptr_low_index = 5'h1C;
        default: ptr_low_index = 5'h1E;
      endcase
    end
  endfunction

  function ds_hits_reg;
    input [15:0] addr;
    begin
      ds_hits_reg = (addr[15:5] == 11'h000);
    end
  endfunction

  assign sp_now = {stack_pointer_high, stack_pointer_low};
  // RULE1 register or immediate operand
  assign op_b = use_imm ? imm : regs[rr_addr];

  csr_alu u_alu (
    .op(alu_op),
    .a(regs[rd_addr]),
    .b(op_b),
    .flags_in(status_flags),
    .result(alu_res),
    .flags_out(alu_flags)
  );

  csr_stack #(.SP_BITS(SP_BITS)) u_stack (
    .sp_op(sp_op),
    .sp_now(sp_now),
    .sp_next(sp_next)
  );

  // ==========================================
  // Pointer addressing
  always @* begin
    ptr_base = {regs[ptr_low_index(ptr_sel) + 5'd1], regs[ptr_low_index(ptr_sel)]};
    ptr_eff = ptr_base;
    ptr_upd = ptr_base;
    ptr_write = 1'b0;
    // RULE17 displacement, post-increment, pre-decrement
    case (ptr_mode)
      `CSR_PM_POSTINC: begin
        ptr_upd = ptr_base + 16'h0001;
        ptr_write = ptr_en;
      end
      `CSR_PM_PREDEC: begin
        ptr_eff = ptr_base - 16'h0001;
        ptr_upd = ptr_eff;
        ptr_write = ptr_en;
      end
      `CSR_PM_DISP: ptr_eff = ptr_base + {10'h000, ptr_disp};
      default: ptr_eff = ptr_base;
    endcase
  end

  // ==========================================
  // Stack operation select
  always @* begin
    if (irq_take) begin
      sp_op = `CSR_SP_IRQ;
    end else if (return_from_irq && !return_from_irq_busy) begin
      sp_op = `CSR_SP_RETURN_FROM_IRQ;
    end else if (return_from_call) begin
      sp_op = `CSR_SP_RET;
    end else if (call_push) begin
      sp_op = `CSR_SP_CALL;
    end else if (byte_push) begin
      sp_op = `CSR_SP_PUSH;
    end else if (byte_pop) begin
      sp_op = `CSR_SP_POP;
    end else begin
      sp_op = `CSR_SP_NONE;
    end
  end

  // ==========================================
  // Flag update
  always @* begin
    next_flags = status_flags;
    // RULE3 flags after each ALU operation
    if (alu_en) begin
      next_flags = alu_flags;
    end
    // RULE8 store bit into copy flag
    if (bit_store) begin
      next_flags[`CSR_FLAG_T] = regs[rd_addr][bit_sel];
    end
    if (io_wr && io_addr == `CSR_IO_FLAGS) begin
      next_flags = io_wdata;
    end
    // RULE7 set and clear enable
    if (set_global_irq) begin
      next_flags[`CSR_FLAG_IE] = 1'b1;
    end
    if (clear_global_irq) begin
      next_flags[`CSR_FLAG_IE] = 1'b0;
    end
    // RULE4 only enable bit touched
    // RULE6 return sets the enable
    if (return_from_irq && !return_from_irq_busy) begin
      next_flags[`CSR_FLAG_IE] = 1'b1;
    end
    // RULE5 entry needs enable set
    // RULE6 entry clears the enable
    if (irq_take && status_flags[`CSR_FLAG_IE]) begin
      next_flags[`CSR_FLAG_IE] = 1'b0;
    end
  end

  // ==========================================
  // Stack pointer next value
  always @* begin
    next_sp_low = sp_next[7:0];
    next_sp_high = sp_next[15:8];
    // RULE21 two 8-bit I/O registers
    // An I/O write wins over a stack step in the same cycle, so software can move the stack.
    if (io_wr && io_addr == `CSR_IO_SPL) begin
      next_sp_low = io_wdata;
      next_sp_high = stack_pointer_high;
    end else if (io_wr && io_addr == `CSR_IO_SPH) begin
      next_sp_low = stack_pointer_low;
      next_sp_high = (SP_BITS > 8) ? io_wdata : 8'h00;
    end
  end

  // ==========================================
  // Interrupt return timing
  always @* begin
    // RULE23 four-cycle interrupt return
    // A second return while busy is ignored, so a strobe held for up to four cycles pops only once.
    if (return_from_irq && !return_from_irq_busy) begin
      next_return_from_irq_cnt = `CSR_RETURN_FROM_IRQ_CYCLES - 3'd1;
      next_return_from_irq_busy = 1'b1;
    end else if (return_from_irq_cnt > 3'd1) begin
      next_return_from_irq_cnt = return_from_irq_cnt - 3'd1;
      next_return_from_irq_busy = return_from_irq_busy;
    end else begin
      next_return_from_irq_cnt = 3'd0;
      next_return_from_irq_busy = 1'b0;
    end
  end

  // ==========================================
  // I/O read select
  always @* begin
    case (io_addr)
      `CSR_IO_FLAGS: next_io_rdata = status_flags;
      `CSR_IO_SPL: next_io_rdata = stack_pointer_low;
      `CSR_IO_SPH: next_io_rdata = stack_pointer_high;
      default: next_io_rdata = 8'h00;
    endcase
  end

  // ==========================================
  // Sequential state
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      // RULE24 reset values
      status_flags <= `CSR_FLAGS_RST;
      stack_pointer_high <= `CSR_SPH_RST;
      stack_pointer_low <= `CSR_SPL_RST;
      return_from_irq_cnt <= 3'd0;
      return_from_irq_busy <= 1'b0;
      irq_enabled <= 1'b0;
      rd_data <= 8'h00;
      rr_data <= 8'h00;
      rd16_data <= 16'h0000;
      alu_result <= 8'h00;
      ptr_addr <= 16'h0000;
      ds_is_reg <= 1'b0;
      ds_rdata <= 8'h00;
      io_rdata <= 8'h00;
    end else begin
      status_flags <= next_flags;
      // RULE5 global enable gates interrupts
      irq_enabled <= next_flags[`CSR_FLAG_IE];
      return_from_irq_cnt <= next_return_from_irq_cnt;
      return_from_irq_busy <= next_return_from_irq_busy;
      stack_pointer_low <= next_sp_low;
      stack_pointer_high <= next_sp_high;
      // RULE15 four port schemes
      rd_data <= regs[rd_addr];
      rr_data <= regs[rr_addr];
      rd16_data <= {regs[rd16_addr | 5'd1], regs[rd16_addr & 5'h1E]};
      alu_result <= alu_res;
      ptr_addr <= ptr_eff;
      // RULE16 registers in low data space
      ds_is_reg <= ds_hits_reg(ds_addr);
      ds_rdata <= ds_hits_reg(ds_addr) ? regs[ds_addr[4:0]] : 8'h00;
      io_rdata <= next_io_rdata;
    end
  end

  // ==========================================
  // Register file writes
  // Registers clear on reset here, although software should not rely on it.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 32; i = i + 1) begin
        regs[i] <= 8'h00;
      end
    end else begin
      // Later writes in this order win; the sequencer issues one kind per cycle.
      if (ptr_write) begin
        regs[ptr_low_index(ptr_sel)] <= ptr_upd[7:0];
        regs[ptr_low_index(ptr_sel) + 5'd1] <= ptr_upd[15:8];
      end
      if (wr16_en) begin
        regs[wr16_addr & 5'h1E] <= wr16_data[7:0];
        regs[wr16_addr | 5'd1] <= wr16_data[15:8];
      end
      if (ds_wr && ds_hits_reg(ds_addr)) begin
        regs[ds_addr[4:0]] <= ds_wdata;
      end
      if (wr8_en) begin
        regs[wr8_addr] <= wr8_data;
      end
      // RULE1 single-cycle result write
      if (alu_en) begin
        regs[rd_addr] <= alu_res;
      end
      // RULE8 load bit from copy flag
      if (bit_load) begin
        regs[rd_addr][bit_sel] <= status_flags[`CSR_FLAG_T];
      end
    end
  end
endmodule // csr_core
`default_nettype wire

// ===== hdl/csr_defs.vh
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
// ==========================================
// Flag register bit positions
`define CSR_FLAG_IE 7
`define CSR_FLAG_T 6
`define CSR_FLAG_H 5
`define CSR_FLAG_S 4
`define CSR_FLAG_V 3
`define CSR_FLAG_N 2
`define CSR_FLAG_Z 1
`define CSR_FLAG_C 0
// ==========================================
// Reset values
`define CSR_FLAGS_RST 8'h00
`define CSR_SPH_RST 8'h00
`define CSR_SPL_RST 8'h9F
// ==========================================
// I/O addresses of the core registers (data address minus 0x20)
`define CSR_IO_SPL 6'h3D
`define CSR_IO_SPH 6'h3E
`define CSR_IO_FLAGS 6'h3F
// ==========================================
// ALU operation codes
`define CSR_OP_ADD 4'h0
`define CSR_OP_ADC 4'h1
`define CSR_OP_SUB 4'h2
`define CSR_OP_SBC 4'h3
`define CSR_OP_AND 4'h4
`define CSR_OP_OR 4'h5
`define CSR_OP_XOR 4'h6
`define CSR_OP_COM 4'h7
`define CSR_OP_NEG 4'h8
`define CSR_OP_INC 4'h9
`define CSR_OP_DEC 4'hA
`define CSR_OP_LSR 4'hB
`define CSR_OP_ROR 4'hC
`define CSR_OP_ASR 4'hD
`define CSR_OP_SWAP 4'hE
`define CSR_OP_MOV 4'hF
// ==========================================
// Stack operation codes
`define CSR_SP_NONE 3'h0
`define CSR_SP_PUSH 3'h1
`define CSR_SP_POP 3'h2
`define CSR_SP_CALL 3'h3
`define CSR_SP_RET 3'h4
`define CSR_SP_IRQ 3'h5
`define CSR_SP_RETURN_FROM_IRQ 3'h6
// ==========================================
// Pointer modes
`define CSR_PM_PLAIN 2'h0
`define CSR_PM_POSTINC 2'h1
`define CSR_PM_PREDEC 2'h2
`define CSR_PM_DISP 2'h3
`define CSR_RETURN_FROM_IRQ_CYCLES 3'd4
`endif

// ===== hdl/csr_stack.v
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.vh"
module csr_stack #(
  parameter SP_BITS = 16
) (
  input wire [2:0] sp_op,
  input wire [15:0] sp_now,
  output reg [15:0] sp_next
);
  reg [15:0] mask;
  always @* begin
    // Bits above SP_BITS are not implemented and read as zero.
    mask = 16'hFFFF >> (16 - SP_BITS);
    case (sp_op)
      // RULE18 push lowers pointer
      // RULE19 push one, call two
      `CSR_SP_PUSH: sp_next = (sp_now - 16'h0001) & mask;
      `CSR_SP_CALL, `CSR_SP_IRQ: sp_next = (sp_now - 16'h0002) & mask;
      // RULE20 pop one, return two
      `CSR_SP_POP: sp_next = (sp_now + 16'h0001) & mask;
      `CSR_SP_RET, `CSR_SP_RETURN_FROM_IRQ: sp_next = (sp_now + 16'h0002) & mask;
      default: sp_next = sp_now & mask;
    endcase
  end
endmodule // csr_stack
`default_nettype wire

// ===== testbench/csr_core_chk.sv
`timescale 1ns/10ps
`default_nettype none
module csr_core_chk #(
  parameter SP_BITS = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic alu_en,
  input wire logic [3:0] alu_op,
  input wire logic io_wr,
  input wire logic bit_store,
  input wire logic bit_load,
  input wire logic set_global_irq,
  input wire logic clear_global_irq,
  input wire logic irq_take,
  input wire logic return_from_irq,
  input wire logic return_from_call,
  input wire logic call_push,
  input wire logic byte_push,
  input wire logic byte_pop,
  input wire logic [7:0] alu_result,
  input wire logic [7:0] status_flags,
  input wire logic [7:0] stack_pointer_high,
  input wire logic [7:0] stack_pointer_low,
  input wire logic irq_enabled,
  input wire logic return_from_irq_busy
);
  // ==========================================
  // Helpers
  wire [15:0] sp = {stack_pointer_high, stack_pointer_low};
  wire [15:0] msk = 16'hFFFF >> (16 - SP_BITS);
  // Swap and move leave the flags alone, so they are kept out.
  wire alu_f = alu_en && !io_wr && !bit_store && !bit_load && alu_op < 4'hE;
  wire sp_free = !io_wr && !irq_take && !return_from_irq && !return_from_call;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_return_from_irq_hold;
    return_from_irq_busy [*3] ##1 !return_from_irq_busy;
  endsequence
  // ==========================================
  // Assertions
  a_sign_is_xor: assert property (alu_f |=> status_flags[4] == (status_flags[2] ^ status_flags[3]))
    else $error("sign flag mismatch");
  a_zero_flag: assert property (alu_f && alu_op != 4'h3 |=> status_flags[1] == (alu_result == 8'h00))
    else $error("zero flag mismatch");
  a_neg_flag: assert property (alu_f |=> status_flags[2] == alu_result[7])
    else $error("negative flag mismatch");
  a_push_dec: assert property (byte_push && sp_free && !call_push |=> sp == (($past(sp) - 16'h0001) & msk))
    else $error("push step wrong");
  a_call_dec: assert property (call_push && sp_free |=> sp == (($past(sp) - 16'h0002) & msk))
    else $error("call step wrong");
  a_pop_inc: assert property (byte_pop && sp_free && !call_push && !byte_push |=> sp == (($past(sp) + 16'h0001) & msk))
    else $error("pop step wrong");
  a_ret_inc: assert property (return_from_call && !irq_take && !return_from_irq && !io_wr |=> sp == (($past(sp) + 16'h0002) & msk))
    else $error("return step wrong");
  a_irq_entry: assert property (irq_take && !io_wr && !alu_en && !bit_store && !bit_load |=> !status_flags[7] && status_flags[6:0] == $past(status_flags[6:0]) && sp == (($past(sp) - 16'h0002) & msk))
    else $error("interrupt entry wrong");
  a_return_from_irq_seq: assert property (return_from_irq && !return_from_irq_busy && !irq_take && !io_wr && !clear_global_irq |=> (irq_enabled && sp == (($past(sp) + 16'h0002) & msk)) ##0 s_return_from_irq_hold)
    else $error("interrupt return wrong");
  a_clear_gie: assert property (clear_global_irq && !set_global_irq && !io_wr && !return_from_irq |=> !irq_enabled)
    else $error("enable not cleared");
endmodule // csr_core_chk
bind csr_core csr_core_chk #(.SP_BITS(SP_BITS)) u_chk (.*);
`default_nettype wire

// ===== testbench/csr_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "csr_defs.vh"
module csr_core_tb;
  logic clk, sys_rst, use_imm, alu_en, wr8_en, wr16_en, bit_store, bit_load, req, io_wr;
  logic set_global_irq, clear_global_irq, irq_take, return_from_irq, return_from_call;
  logic call_push, byte_push, byte_pop, ptr_en, ds_wr, irq_enabled, ds_is_reg, return_from_irq_busy;
  logic [4:0] rd_addr, rr_addr, wr8_addr, wr16_addr, rd16_addr;
  logic [7:0] imm, wr8_data, ds_wdata, io_wdata, dreq, rd_data, rr_data, alu_result;
  logic [7:0] status_flags, stack_pointer_high, stack_pointer_low, ds_rdata, io_rdata;
  logic [3:0] alu_op;
  logic [2:0] bit_sel;
  logic [1:0] ptr_sel, ptr_mode;
  logic [5:0] ptr_disp, io_addr, areq;
  logic [15:0] wr16_data, ds_addr, rd16_data, ptr_addr;
  int n_fail, n_checks;
  csr_core dut (.*);
  csr_seq_model u_seq (.*);
  // ==========================================
  // Common tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk) #1;
    {alu_en, wr8_en, wr16_en, bit_store, bit_load, set_global_irq, clear_global_irq} = '0;
    {irq_take, return_from_irq, return_from_call, call_push, byte_push, byte_pop} = '0;
    {ptr_en, ds_wr, req} = '0;
  endtask
  task automatic io_w(input logic [5:0] a, input logic [7:0] d);
    areq = a;
    dreq = d;
    req = 1'b1;
    tick;
    tick;
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 33; i++) begin
      ds_addr = 16'(i);
      rd_addr = 5'(i);
      ds_wdata = 8'(i) ^ 8'hA5;
      ds_wr = 1'b1;
      tick;
      tick;
      chk(ds_is_reg, i < 32);
      chk(ds_rdata, i < 32 ? ds_wdata : 8'h00);
      if (i < 32) chk(rd_data, ds_wdata);
    end
  endtask
  task automatic t_alu;
    logic [35:0] tv [5] = '{36'h0_7F_01_80_2C, 36'h0_FF_01_00_23, 36'h2_00_01_FF_35,
      36'h4_0F_F0_00_23, 36'h7_55_00_AA_35};
    foreach (tv[k]) begin
      wr8_addr = 5'h03;
      wr8_data = tv[k][31:24];
      wr8_en = 1'b1;
      tick;
      {rd_addr, imm, use_imm, alu_op, alu_en} = {5'h03, tv[k][23:16], 1'b1, tv[k][35:32], 1'b1};
      tick;
      chk(alu_result, tv[k][15:8]);
      chk(status_flags, tv[k][7:0]);
      tick;
      chk(rd_data, tv[k][15:8]);
    end
    {rd_addr, rr_addr, use_imm, alu_op, alu_en} = {5'h06, 5'h00, 1'b0, `CSR_OP_MOV, 1'b1};
    tick;
    chk(rr_data, 8'hA5);
    chk(alu_result, 8'hA5);
  endtask
  task automatic t_bits;
    {rd_addr, bit_sel, bit_store} = {5'h03, 3'h1, 1'b1};
    tick;
    chk(status_flags[6], 1'b1);
    {bit_sel, bit_load} = {3'h0, 1'b1};
    tick;
    tick;
    chk(rd_data, 8'hAB);
    {bit_sel, bit_store} = {3'h2, 1'b1};
    tick;
    chk(status_flags[6], 1'b0);
  endtask
  task automatic t_ptr;
    {wr16_addr, wr16_data, wr16_en, rd16_addr, rd_addr} = {5'h1E, 16'h1234, 1'b1, 5'h1E, 5'h1F};
    tick;
    tick;
    chk(rd16_data, 16'h1234);
    chk(rd_data, 8'h12);
    for (int m = 0; m < 4; m++) begin
      {ptr_sel, ptr_mode, ptr_disp, ptr_en} = {2'h2, 2'(m), 6'h3F, 1'b1};
      tick;
      chk(ptr_addr, m == 3 ? 16'h1273 : 16'h1234);
      tick;
      chk(rd16_data, m == 1 ? 16'h1235 : 16'h1234);
    end
  endtask
  task automatic t_irq;
    io_w(`CSR_IO_SPH, 8'h01);
    io_w(`CSR_IO_SPL, 8'h00);
    chk(io_rdata, `CSR_SPL_RST);
    io_w(`CSR_IO_FLAGS, 8'h55);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0100);
    set_global_irq = 1'b1;
    tick;
    chk(irq_enabled, 1'b1);
    irq_take = 1'b1;
    tick;
    chk(status_flags, 8'h55);
    chk({stack_pointer_high, stack_pointer_low}, 16'h00FE);
    return_from_irq = 1'b1;
    tick;
    chk(status_flags, 8'hD5);
    chk({stack_pointer_high, stack_pointer_low}, 16'h0100);
    return_from_irq = 1'b1;
    tick;
    chk({stack_pointer_high, stack_pointer_low}, 16'h0100);
    tick;
    chk(return_from_irq_busy, 1'b1);
    tick;
    chk(return_from_irq_busy, 1'b0);
    clear_global_irq = 1'b1;
    tick;
    chk(irq_enabled, 1'b0);
  endtask
  task automatic t_stack;
    logic [19:0] sv [4] = '{20'h1_00FF, 20'h2_00FD, 20'h3_00FE, 20'h4_0100};
    foreach (sv[k]) begin
      {byte_push, call_push, byte_pop, return_from_call} = 4'h8 >> (sv[k][19:16] - 4'h1);
      tick;
      chk({stack_pointer_high, stack_pointer_low}, sv[k][15:0]);
    end
  endtask
  // ==========================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    n_fail = 0;
    n_checks = 0;
    {sys_rst, use_imm, alu_en, wr8_en, wr16_en, bit_store, bit_load, req} = 8'h80;
    {set_global_irq, clear_global_irq, irq_take, return_from_irq, return_from_call} = '0;
    {call_push, byte_push, byte_pop, ptr_en, ds_wr} = '0;
    {rd_addr, rr_addr, wr8_addr, wr16_addr, rd16_addr, imm, wr8_data, ds_wdata} = '0;
    {dreq, alu_op, bit_sel, ptr_sel, ptr_mode, ptr_disp, areq, wr16_data, ds_addr} = '0;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(status_flags, `CSR_FLAGS_RST);
    chk({stack_pointer_high, stack_pointer_low}, 16'h009F);
    t_regs;
    t_alu;
    t_bits;
    t_ptr;
    t_irq;
    t_stack;
    conclude;
  end
endmodule // csr_core_tb
`default_nettype wire

// ===== testbench/csr_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Sequencer I/O write path
module csr_seq_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [5:0] areq,
  input wire logic [7:0] dreq,
  output var logic io_wr,
  output var logic [5:0] io_addr,
  output var logic [7:0] io_wdata
);
  initial begin
    io_wr = 1'b0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
  end
  // Released lines toggle so a stale value is never mistaken for data.
  always @(posedge clk) begin
    io_wr <= req;
    io_addr <= req ? areq : ~io_addr;
    io_wdata <= req ? dreq : ~io_wdata;
  end
endmodule // csr_seq_model
`default_nettype wire
